// ==== pcac_cfg.sv ====
// The AXI4-Lite register port was left to the implementer.
`include "pcac_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pcac_cfg
    import pcac_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Low power mode pins
    input  wire logic        wait_mode,
    input  wire logic        freeze_mode,
    // Scaled clock ticks from the outside scaler
    input  wire logic        scaled_clock_a,
    input  wire logic        scaled_clock_b,
    // Channel clock and mode outputs
    output logic             clock_a_tick,
    output logic             clock_b_tick,
    output logic [7:0]       channel_clock_tick,
    output logic [7:0]       center_align_bit,
    output logic [3:0]       join_pair,
    output logic [7:0]       channel_owner
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
        $error("CHANNELS must be 1 to 8");
    end

    // Implemented channel mask; other bits ignore writes and read zero.
    localparam logic [7:0] CH_MASK = 8'(({8'h00, 8'hff} >> (8 - CHANNELS)));
    logic [7:0] join_mask;

    // Pair k exists only if both of its channels exist.
    always_comb begin
        join_mask = 8'h00;
        for (int k = 0; k < 4; k++) begin
            join_mask[`PCAC_CTL_JOIN_LSB + k] = CH_MASK[2 * k + 1];
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {scaled_clock_b, scaled_clock_a, freeze_mode, wait_mode};
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0] clk_sel_q;
    logic [7:0] pair_pick_q;
    logic [7:0] prescale_q;
    logic [7:0] align_q;
    logic [7:0] ctl_q;

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  aw_idx_q;
    logic        aw_bad_q;
    logic [7:0]  w_byte_q;
    logic        w_lane_q;
    logic        wr_fire;
    logic [3:0]  aw_idx_now;
    logic        aw_bad_now;
    logic [7:0]  w_byte_now;
    logic        w_lane_now;

    assign aw_idx_now = aw_held_q ? aw_idx_q : s_axi_awaddr[5:2];
    assign aw_bad_now = aw_held_q ? aw_bad_q : (s_axi_awaddr[31:6] != 26'h0);
    assign w_byte_now = w_held_q ? w_byte_q : s_axi_wdata[7:0];
    assign w_lane_now = w_held_q ? w_lane_q : s_axi_wstrb[0];
    assign wr_fire    = (aw_held_q || (s_axi_awvalid && s_axi_awready))
                      && (w_held_q || (s_axi_wvalid && s_axi_wready))
                      && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_idx_q      <= 4'h0;
            aw_bad_q      <= 1'b0;
            w_byte_q      <= 8'h00;
            w_lane_q      <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    aw_idx_q  <= s_axi_awaddr[5:2];
                    aw_bad_q  <= (s_axi_awaddr[31:6] != 26'h0);
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    w_byte_q <= s_axi_wdata[7:0];
                    w_lane_q <= s_axi_wstrb[0];
                end
            end
            s_axi_awready <= !s_axi_awready && !aw_held_q && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready  <= !s_axi_wready && !w_held_q && s_axi_wvalid && !s_axi_bvalid;
        end
    end

    logic wr_hit;

    always_comb begin
        wr_hit = 1'b0;
        if (!aw_bad_now) begin
            case (aw_idx_now)
                `PCAC_IDX_CLK_SEL,
                `PCAC_IDX_PRESCALE,
                `PCAC_IDX_ALIGN,
                `PCAC_IDX_CTL,
                `PCAC_IDX_PAIR_PICK: wr_hit = 1'b1;
                default:             wr_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= PCAC_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? PCAC_OKAY : PCAC_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Writes take effect at any time, even while channels run.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sel_q   <= `PCAC_RESET_BYTE;
            pair_pick_q <= `PCAC_RESET_BYTE;
            prescale_q  <= `PCAC_RESET_BYTE;
            align_q     <= `PCAC_RESET_BYTE;
            ctl_q       <= `PCAC_RESET_BYTE;
        end else if (wr_fire && w_lane_now && !aw_bad_now) begin
            case (aw_idx_now)
                `PCAC_IDX_CLK_SEL:   clk_sel_q   <= w_byte_now & CH_MASK;
                `PCAC_IDX_PAIR_PICK: pair_pick_q <= w_byte_now & CH_MASK;
                `PCAC_IDX_PRESCALE:  prescale_q  <= w_byte_now & `PCAC_PRESCALE_MASK;
                `PCAC_IDX_ALIGN:     align_q     <= w_byte_now & CH_MASK;
                `PCAC_IDX_CTL:       ctl_q       <= w_byte_now & (`PCAC_CTL_MASK & (join_mask | 8'h0f));
                default:             ;
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    logic [7:0] rd_byte;
    logic       rd_hit;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (s_axi_araddr[31:6] != 26'h0) begin
            rd_hit = 1'b0;
        end else begin
            case (s_axi_araddr[5:2])
                `PCAC_IDX_CLK_SEL:   rd_byte = clk_sel_q;
                `PCAC_IDX_PAIR_PICK: rd_byte = pair_pick_q;
                `PCAC_IDX_PRESCALE:  rd_byte = prescale_q;
                `PCAC_IDX_ALIGN:     rd_byte = align_q;
                `PCAC_IDX_CTL:       rd_byte = ctl_q;
                default:             rd_hit  = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= PCAC_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, rd_byte};
                s_axi_rresp  <= rd_hit ? PCAC_OKAY : PCAC_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    logic [`PCAC_PRESCALE_BITS-1:0] pre_cnt_q;
    logic                           pre_run;
    logic [7:0]                     pre_cur;
    logic [7:0]                     pre_next;
    logic [2:0]                     rate_a;
    logic [2:0]                     rate_b;
    logic                           tick_a;
    logic                           tick_b;

    assign pre_run = !((ctl_q[`PCAC_CTL_WAIT_BIT] && sync2_q[0])
                    || (ctl_q[`PCAC_CTL_FREEZE_BIT] && sync2_q[1]));
    assign pre_cur  = {1'b0, pre_cnt_q};
    assign pre_next = pre_cur + 8'h01;
    assign rate_a   = prescale_q[`PCAC_RATE_A_LSB +: 3];
    assign rate_b   = prescale_q[`PCAC_RATE_B_LSB +: 3];
    // A tick each time the low n bits roll over; the spare top bit lets n reach seven.
    assign tick_a   = pre_run && (pre_next[rate_a] != pre_cur[rate_a]);
    assign tick_b   = pre_run && (pre_next[rate_b] != pre_cur[rate_b]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= '0;
        end else if (pre_run) begin
            pre_cnt_q <= pre_next[`PCAC_PRESCALE_BITS-1:0];
        end
    end

    // ----------------------------------------
    // Scaled clock edge detection
    // ----------------------------------------
    logic [1:0] scaled_last_q;
    logic       tick_sa;
    logic       tick_sb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scaled_last_q <= 2'h0;
        end else begin
            scaled_last_q <= sync2_q[3:2];
        end
    end

    assign tick_sa = pre_run && sync2_q[2] && !scaled_last_q[0];
    assign tick_sb = pre_run && sync2_q[3] && !scaled_last_q[1];

    // ----------------------------------------
    // Per-channel source selection
    // ----------------------------------------
    wire logic [7:0] ch_tick;

    for (genvar c = 0; c < 8; c++) begin : g_ch
        localparam bit SWAP = (c % 4) >= 2;
        pcac_src_type src;
        logic         pick;
        always_comb begin
            src = pcac_src_type'({pair_pick_q[c] ^ SWAP, clk_sel_q[c]});
            case (src)
                PCAC_SRC_A:  pick = tick_a;
                PCAC_SRC_SA: pick = tick_sa;
                PCAC_SRC_B:  pick = tick_b;
                PCAC_SRC_SB: pick = tick_sb;
                default:     pick = 1'b0;
            endcase
        end
        assign ch_tick[c] = pick;
    end

    // ----------------------------------------
    // Outputs and pairing
    // ----------------------------------------
    logic [7:0] owner;
    logic [7:0] eff_tick;
    logic [7:0] eff_align;

    // A joined even channel follows its odd partner; owner flags that governed even channel.
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            owner[c]     = 1'b0;
            eff_tick[c]  = ch_tick[c];
            eff_align[c] = align_q[c];
        end
        for (int k = 0; k < 4; k++) begin
            if (ctl_q[`PCAC_CTL_JOIN_LSB + k]) begin
                owner[2 * k]        = 1'b1;
                eff_tick[2 * k]     = ch_tick[2 * k + 1];
                eff_align[2 * k]    = align_q[2 * k + 1];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_a_tick       <= 1'b0;
            clock_b_tick       <= 1'b0;
            channel_clock_tick <= 8'h00;
            center_align_bit   <= 8'h00;
            join_pair          <= 4'h0;
            channel_owner      <= 8'h00;
        end else begin
            clock_a_tick       <= tick_a;
            clock_b_tick       <= tick_b;
            channel_clock_tick <= eff_tick & CH_MASK;
            center_align_bit   <= eff_align & CH_MASK;
            join_pair          <= ctl_q[`PCAC_CTL_JOIN_LSB +: 4];
            channel_owner      <= owner;
        end
    end

endmodule

`default_nettype wire

// ==== pcac_cfg_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcac_cfg_assertions
    import pcac_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Channel outputs
    input wire logic [7:0]  channel_clock_tick,
    input wire logic [7:0]  center_align_bit,
    input wire logic [3:0]  join_pair,
    input wire logic [7:0]  channel_owner
);
    localparam logic [7:0] LIVE = 8'((1 << CHANNELS) - 1);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_far_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[31:6] != 26'h0;
    endsequence
    property p_wr_resp;
        s_wr_taken |=> s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_aw_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
    property p_far_read;
        s_far_read |=> s_axi_rresp == PCAC_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_far_read: assert property (p_far_read) else $error("far read not refused");
    property p_owner;
        $stable(join_pair) |-> channel_owner == {1'b0, join_pair[3], 1'b0, join_pair[2],
            1'b0, join_pair[1], 1'b0, join_pair[0]};
    endproperty
    a_owner: assert property (p_owner) else $error("owner flags wrong");
    property p_join_copy;
        join_pair[0] && $past(join_pair[0]) |-> channel_clock_tick[0] == channel_clock_tick[1]
            && center_align_bit[0] == center_align_bit[1];
    endproperty
    a_join_copy: assert property (p_join_copy) else $error("pair not copied");
    property p_absent;
        ((channel_clock_tick | center_align_bit | channel_owner) & ~LIVE) == 8'h00;
    endproperty
    a_absent: assert property (p_absent) else $error("absent channel active");
endmodule
`default_nettype wire

// ==== pcac_defs.svh ====
// Summary of operation
// - Per-channel bit picks unscaled clock when clear, scaled clock when set.
// - Channels 0,1,4,5: 00 A, 01 scaled A, 10 B, 11 scaled B.
// - Channels 2,3,6,7: 00 B, 01 scaled B, 10 A, 11 scaled A.
// - Clock-select writes accepted anytime; one pulse may be cut or stretched.
// - Prescale register: bits 6-4 rate of clock B, bits 2-0 rate of A.
// - Field value n divides the bus clock by two to the power n.
// - Prescale writes accepted anytime; a running pulse may be cut or stretched.
// - Per-channel align bit: zero left aligned, one center aligned.
// - Up to four pairing bits each join two adjacent channels into 16 bits.
// - In a joined pair the even channel is high byte, odd is low.
// - Bits of missing channels ignore writes and read back as zero.
// - Joined pair uses the odd channel's settings and output line.
// - Control bit 3 stops the prescaler input clock during wait mode.
// - Control bit 2 stops the prescaler clock in freeze; registers stay reachable.
`ifndef PCAC_DEFS_SVH
`define PCAC_DEFS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define PCAC_IDX_CLK_SEL    4'h2
`define PCAC_IDX_PRESCALE   4'h3
`define PCAC_IDX_ALIGN      4'h4
`define PCAC_IDX_CTL        4'h5
`define PCAC_IDX_PAIR_PICK  4'h6

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PCAC_RATE_A_LSB     0
`define PCAC_RATE_B_LSB     4
`define PCAC_CTL_FREEZE_BIT 2
`define PCAC_CTL_WAIT_BIT   3
`define PCAC_CTL_JOIN_LSB   4
`define PCAC_PRESCALE_MASK  8'h77
`define PCAC_CTL_MASK       8'hfc
`define PCAC_RESET_BYTE     8'h00
`define PCAC_PRESCALE_BITS  7

`endif

// ==== pcac_pkg.sv ====
`default_nettype none
package pcac_pkg;
    typedef enum logic [1:0] {
        PCAC_SRC_A  = 2'h0,
        PCAC_SRC_SA = 2'h1,
        PCAC_SRC_B  = 2'h2,
        PCAC_SRC_SB = 2'h3
    } pcac_src_type;
    typedef logic [1:0] pcac_resp_type;
    localparam pcac_resp_type PCAC_OKAY   = 2'h0;
    localparam pcac_resp_type PCAC_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcac_pkg::*;
    localparam int         CH      = 6;
    localparam logic [7:0] LIVE    = 8'((1 << CH) - 1);
    localparam logic [3:0] PAIRS   = 4'((1 << (CH / 2)) - 1);
    localparam logic [7:0] ADDR[5] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    localparam logic [7:0] MASK[5] = '{LIVE, 8'h77, LIVE, {PAIRS, 4'hc}, LIVE};
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sca, scb;
    logic        awready, wready, bvalid, arready, rvalid, wait_mode, freeze_mode;
    logic        ca_tick, cb_tick;
    logic [31:0] awaddr, wdata, araddr, rdata, rnd;
    logic [7:0]  ch_tick, align, owner, v;
    logic [3:0]  wstrb, join_pair;
    logic [1:0]  bresp, rresp;
    logic [33:0] exp_q[$];
    int          fails, checks_done, cyc, g;
    int          cnt[10];
    wire  [9:0]  tk = {cb_tick, ca_tick, ch_tick};
    pcac_cfg #(.CHANNELS(CH)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wait_mode(wait_mode), .freeze_mode(freeze_mode), .scaled_clock_a(sca),
        .scaled_clock_b(scb), .clock_a_tick(ca_tick), .clock_b_tick(cb_tick),
        .channel_clock_tick(ch_tick), .center_align_bit(align), .join_pair(join_pair),
        .channel_owner(owner)
    );
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [33:0] seen, input logic [33:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, want, seen);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] resp(input logic [7:0] a);
        return (a inside {ADDR}) ? PCAC_OKAY : PCAC_SLVERR;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        exp_q.push_back({resp(a), 32'h0});
        awaddr <= {24'h0, a};
        wdata <= {rnd[31:8], d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        exp_q.push_back({resp(a), 24'h0, d});
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    // Bus answers are matched against the oldest noted expectation.
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (exp_q.size() == 0)
                check("queue", 34'h1, 34'h0);
            else
                check("bus", bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
        end
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        sca <= cyc[2];
        scb <= cyc[4];
        if (cyc == 40000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic tally(input int n);
        cnt = '{default: 0};
        repeat (n) begin
            @(posedge aclk);
            foreach (cnt[i]) cnt[i] += int'(tk[i]);
        end
    endtask
    task automatic gap(input int b, output int w);
        repeat (2) do @(posedge aclk); while (tk[b] !== 1'b1);
        w = 0;
        do begin
            @(posedge aclk);
            w++;
        end while (tk[b] !== 1'b1);
    endtask
    // Tick counts over 64 cycles: A 64, B 16, scaled A 8, scaled B 2, none 0.
    function automatic int cls(input int k);
        return k > 40 ? 0 : k > 11 ? 2 : k > 4 ? 1 : k > 0 ? 3 : 4;
    endfunction
    function automatic int src(input int c, input logic [7:0] s, p, input logic [3:0] j);
        int o;
        o = (j[c / 2] && c % 2 == 0) ? c + 1 : c;
        return c >= CH ? 4 : int'({p[o] ^ o[1], s[o]});
    endfunction
    task automatic mix(input logic [7:0] s, p, al, input logic [3:0] j);
        logic [3:0] ej;
        logic [7:0] ea, eo;
        int         o;
        ej = j & PAIRS;
        wr(ADDR[0], s);
        wr(ADDR[4], p);
        wr(ADDR[2], al);
        wr(ADDR[3], {j, 4'h0});
        tally(8);
        tally(64);
        for (int c = 0; c < 8; c++) begin
            o = (ej[c / 2] && c % 2 == 0) ? c + 1 : c;
            ea[c] = c < CH && al[o];
            eo[c] = c % 2 == 0 && ej[c / 2];
            check("source", 34'(cls(cnt[c])), 34'(src(c, s, p, ej)));
        end
        check("align", 34'(align), 34'(ea));
        check("join", 34'(join_pair), 34'(ej));
        check("owner", 34'(owner), 34'(eo));
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, wait_mode, freeze_mode} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        rnd = 32'h2b09e86f;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ADDR[i]) rd(ADDR[i], 8'h00);
        repeat (2) foreach (ADDR[i]) begin
            rnd = lfsr(rnd);
            wr(ADDR[i], rnd[7:0]);
            rd(ADDR[i], rnd[7:0] & MASK[i]);
        end
        wr(ADDR[0], 8'h5a);
        rd(8'h1c, 8'h00);
        rd(8'h5c, 8'h00);
        wr(8'h48, 8'hff);
        wstrb <= 4'h0;
        wr(ADDR[0], 8'hff);
        wstrb <= 4'hf;
        rd(ADDR[0], 8'h5a & LIVE);
        for (int n = 0; n < 8; n++) begin
            wr(ADDR[1], 8'(((7 - n) << 4) | n));
            gap(8, g);
            check("rate a", 34'(g), 34'(1 << n));
            gap(9, g);
            check("rate b", 34'(g), 34'(1 << (7 - n)));
        end
        wr(ADDR[1], 8'h00);
        for (int k = 0; k < 4; k++) begin
            v = k[0] ? (k[1] ? 8'h08 : 8'h04) : 8'h00;
            wr(ADDR[3], v);
            wait_mode <= k[1];
            freeze_mode <= !k[1];
            tally(8);
            tally(32);
            check("halt", 34'(cnt[8]), k[0] ? 34'h0 : 34'd32);
            rd(ADDR[3], v);
        end
        wait_mode <= 1'b0;
        freeze_mode <= 1'b0;
        wr(ADDR[1], 8'h20);
        for (int m = 0; m < 4; m++) mix({8{m[0]}}, {8{m[1]}}, rnd[7:0], 4'h0);
        repeat (3) begin
            rnd = lfsr(rnd);
            mix(rnd[7:0], rnd[15:8], rnd[23:16], rnd[27:24]);
        end
        print_verdict();
    end
endmodule
bind pcac_cfg pcac_cfg_assertions #(.CHANNELS(CHANNELS)) u_chk (.*);
`default_nettype wire
